// ### hdl/dsp_parallel_pair_checker.sv
`timescale 1ns/1ns
// Function
// - byte access to a memory-mapped register raises a bus-error request
// - coefficient pointer: plain, increment, decrement, indexed by mode-selected register
// - long-offset indirect operands may not access I/O space
// - delay instructions may not access I/O space
// - any illegal I/O access raises a bus-error request
// - long modifier moves one true 32-bit operand
// - dual modifier splits a 32-bit operand into two 16-bit halves
// - accumulator half select picks upper or lower 16 bits
// - byte select reads or writes only the high or low byte
// - paired coefficient operands agree on unsigned marking
// - paired dual operands agree on unsigned marking
// - single-repeat rejects flow, status, page, return-address, counter, round
// - two instructions may issue in one cycle
// - pair needs a parallel enable bit or soft-dual qualification
// - no 16-bit-or-wider address constant within a pair
// - far branch/call, idle, interrupt, reset, trap never pair
// - no circular, linear, register-space or port qualifiers in a pair
// - one write per register per phase, incl. pointer and swap conflicts
// - stack pointer writes do not pair with call, push, pop, return, trap
// - a status bit written by both becomes undefined
// - pair uses the union of resources, overuse is a conflict
// - each operator serves only one instruction of a pair
// - shared operator between multi-operator instructions forbids pairing
module dsp_parallel_pair_checker (
	input  wire logic                            sys_clk,
	input  wire logic                            sys_rst,
	input  wire logic                            decodeValid,
	input  wire pair_check_pkg::slot_t           slotA,
	input  wire pair_check_pkg::slot_t           slotB,
	input  wire logic                            repeatActive,
	input  wire logic                            legacy_compat_mode,
	input  wire logic [15:0]                     temp_register_zero,
	input  wire logic [15:0]                     aux_register_zero,
	input  wire logic [15:0]                     coefficient_pointer,
	input  wire logic [31:0]                     memReadData,
	input  wire logic [39:0]                     accValue,
	output logic                                 illegalPair,
	output logic                                 illegalRepeat,
	output logic                                 bus_error_irq,
	output logic                                 issueDual,
	output logic [pair_check_pkg::ST_W-1:0]      statusUndefined,
	output logic [15:0]                          coefAddr,
	output logic [15:0]                          coefPtrNext,
	output logic [31:0]                          operandLong,
	output logic [15:0]                          operandHigh,
	output logic [15:0]                          operandLow,
	output logic [15:0]                          accOperand,
	output logic [7:0]                           byteOperand
);
	import pair_check_pkg::*;

	slot_bus_if sbA ();
	slot_bus_if sbB ();

	slot_check uSlotA (
		.slot (slotA),
		.sb   (sbA)
	);
	slot_check uSlotB (
		.slot (slotB),
		.sb   (sbB)
	);

	// both slots present makes a pair
	wire bothValid = decodeValid & slotA.valid & slotB.valid;

	// enable bit or soft-dual qualification
	wire enableOk = slotA.parEnable | slotB.parEnable | (slotA.softDualOk & slotB.softDualOk);

	// forbidden modes, classes and qualifiers
	wire formBad = sbA.noPair | sbB.noPair | sbA.forbidQual | sbB.forbidQual;

	// unsigned marking must agree on coefficient and dual operands
	wire coefUnsBad = slotA.usesCoef & slotB.usesCoef & (slotA.coefUns ^ slotB.coefUns);
	wire coefFormBad = slotA.usesCoef & slotB.usesCoef & (slotA.coefForm != slotB.coefForm);
	wire xyUnsBadA = slotA.usesXY & (slotA.xUns ^ slotA.yUns);
	wire xyUnsBadB = slotB.usesXY & (slotB.xUns ^ slotB.yUns);
	wire unsBad = coefUnsBad | xyUnsBadA | xyUnsBadB | coefFormBad;

	// write-once per phase, swaps claim all their registers
	wire [REG_W-1:0] claimA = slotA.regWrites | slotA.swapRegs;
	wire [REG_W-1:0] claimB = slotB.regWrites | slotB.swapRegs;
	wire regDouble = |(claimA & claimB);
	wire ptrClash = slotA.ptrMod & slotB.ptrMod & (slotA.ptrIdx == slotB.ptrIdx)
		& (slotA.ptrKind != slotB.ptrKind);
	wire writeBad = regDouble | ptrClash;

	// stack pointer change versus stack-using flow
	wire stackBad = (slotA.modStackPtr & sbB.stackCall) | (slotB.modStackPtr & sbA.stackCall);

	// operators may be used by one side only, whatever else they use
	wire opBad = |(slotA.ops & slotB.ops);

	// union of unit and bus counts against limits
	wire [CNT_W:0] daSum  = {1'b0, slotA.daUse} + {1'b0, slotB.daUse};
	wire [CNT_W:0] drSum  = {1'b0, slotA.drUse} + {1'b0, slotB.drUse};
	wire [CNT_W:0] dwSum  = {1'b0, slotA.dwUse} + {1'b0, slotB.dwUse};
	wire [CNT_W:0] caSum  = {2'b00, slotA.caUse} + {2'b00, slotB.caUse};
	wire [CNT_W:0] saSum  = {2'b00, slotA.saUse} + {2'b00, slotB.saUse};
	wire [CNT_W:0] crSum  = {2'b00, slotA.crUse} + {2'b00, slotB.crUse};
	wire [CNT_W:0] acbSum = {2'b00, slotA.acbUse} + {2'b00, slotB.acbUse};
	wire resBad = (daSum > (CNT_W+1)'(DA_MAX)) | (drSum > (CNT_W+1)'(DR_MAX))
		| (dwSum > (CNT_W+1)'(DW_MAX)) | (caSum > (CNT_W+1)'(CA_MAX))
		| (saSum > (CNT_W+1)'(SA_MAX)) | (crSum > (CNT_W+1)'(CR_MAX))
		| (acbSum > (CNT_W+1)'(ACB_MAX));

	// any violation blocks the pair
	wire pairBad = bothValid & (~enableOk | formBad | unsBad | writeBad | stackBad | opBad | resBad);
	wire pairOk  = bothValid & ~pairBad;

	// status bits written by both sides
	wire [ST_W-1:0] stClash = (bothValid ? (slotA.stWrites & slotB.stWrites) : {ST_W{1'b0}});

	// repeated instructions under an active single-repeat are slot A and, when both slots are valid, slot B
	wire repBad = decodeValid & repeatActive & (sbA.noRepeat | (bothValid & sbB.noRepeat));

	// bus errors from either slot
	wire busErr = decodeValid & (sbA.mmrByteFault | sbB.mmrByteFault | sbA.ioFault | sbB.ioFault);

	// coefficient address generation; every form addresses the pointer itself, and all but CP_PLAIN then modify it
	wire [15:0] coefIndex = legacy_compat_mode ? aux_register_zero : temp_register_zero;
	logic [15:0] coefAddrD;
	logic [15:0] coefNextD;
	always_comb begin
		coefAddrD = coefficient_pointer;
		coefNextD = coefficient_pointer;
		unique case (slotA.coefForm)
			CP_PLAIN: begin
				coefNextD = coefficient_pointer;
			end
			CP_INC: begin
				coefNextD = coefficient_pointer + 16'h0001;
			end
			CP_DEC: begin
				coefNextD = coefficient_pointer - 16'h0001;
			end
			CP_INDEX: begin
				coefNextD = coefficient_pointer + coefIndex;
			end
		endcase
	end

	// operand shaping by modifier
	wire [31:0] longD  = memReadData;
	wire [15:0] highD  = memReadData[31:16];
	wire [15:0] lowD   = memReadData[15:0];
	wire [15:0] accD   = (slotA.accHalf == ACC_UPPER) ? accValue[31:16] : accValue[15:0];
	wire [7:0]  byteD  = slotA.byteHigh ? memReadData[15:8] : memReadData[7:0];
	// operands load only on a decode cycle so they hold between decodes
	wire byteOk = decodeValid & slotA.valid & (slotA.width == MW_BYTE) & ~slotA.isMmr;
	wire longOk = decodeValid & slotA.valid & (slotA.width == MW_LONG);
	wire dualOk = decodeValid & slotA.valid & (slotA.width == MW_DUAL);
	wire accOk  = decodeValid & slotA.valid & (slotA.accHalf != ACC_FULL);

	// decode-cycle flags
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			illegalPair     <= 1'b0;
			illegalRepeat   <= 1'b0;
			bus_error_irq   <= 1'b0;
			issueDual       <= 1'b0;
			statusUndefined <= '0;
		end else begin
			illegalPair     <= pairBad;
			illegalRepeat   <= repBad;
			bus_error_irq   <= busErr;
			issueDual       <= pairOk;
			statusUndefined <= stClash;
		end
	end

	// coefficient address registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			coefAddr    <= 16'h0000;
			coefPtrNext <= 16'h0000;
		end else if (decodeValid & slotA.usesCoef) begin
			coefAddr    <= coefAddrD;
			coefPtrNext <= coefNextD;
		end
	end

	// memory operand registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			operandLong <= 32'h00000000;
			operandHigh <= 16'h0000;
			operandLow  <= 16'h0000;
		end else begin
			if (longOk) begin
				operandLong <= longD;
			end
			if (dualOk) begin
				operandHigh <= highD;
				operandLow  <= lowD;
			end
		end
	end

	// accumulator half and byte registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			accOperand  <= 16'h0000;
			byteOperand <= 8'h00;
		end else begin
			if (accOk) begin
				accOperand <= accD;
			end
			if (byteOk) begin
				byteOperand <= byteD;
			end
		end
	end

endmodule : dsp_parallel_pair_checker

// ### hdl/pair_check_pkg.sv
package pair_check_pkg;

	// operator resource bits, one per unit
	localparam int OP_W          = 6;
	localparam int OP_DALU       = 0;
	localparam int OP_DSHIFT     = 1;
	localparam int OP_DSWAP      = 2;
	localparam int OP_ASWAP      = 3;
	localparam int OP_AALU       = 4;
	localparam int OP_PUNIT      = 5;

	// resource limits per pair
	localparam int DA_MAX        = 2;
	localparam int CA_MAX        = 1;
	localparam int SA_MAX        = 1;
	localparam int DR_MAX        = 2;
	localparam int CR_MAX        = 1;
	localparam int DW_MAX        = 2;
	localparam int ACB_MAX       = 1;
	localparam int CNT_W         = 2;

	// register-file write targets and status bits
	localparam int REG_W         = 32;
	localparam int ST_W          = 16;
	localparam int IDX_W         = 4;

	// instruction class codes
	localparam int CLS_W         = 5;
	typedef enum logic [CLS_W-1:0] {
		CLS_PLAIN      = 5'h00,
		CLS_BRANCH     = 5'h01,
		CLS_BRANCH_FAR = 5'h02,
		CLS_CALL       = 5'h03,
		CLS_CALL_FAR   = 5'h04,
		CLS_RETURN     = 5'h05,
		CLS_RETINT     = 5'h06,
		CLS_IDLE       = 5'h07,
		CLS_REPEAT     = 5'h08,
		CLS_INTR       = 5'h09,
		CLS_TRAP       = 5'h0A,
		CLS_RESET      = 5'h0B,
		CLS_STBIT      = 5'h0C,
		CLS_DPLOAD     = 5'h0D,
		CLS_RETALOAD   = 5'h0E,
		CLS_RETASTORE  = 5'h0F,
		CLS_RPTCREAD   = 5'h10,
		CLS_ROUND      = 5'h11,
		CLS_PUSH       = 5'h12,
		CLS_POP        = 5'h13,
		CLS_SWAP       = 5'h14,
		CLS_DELAY      = 5'h15
	} instrClass_t;

	// memory addressing mode codes
	typedef enum logic [2:0] {
		AM_NONE      = 3'h0,
		AM_INDIRECT  = 3'h1,
		AM_ABS16     = 3'h2,
		AM_ABS23     = 3'h3,
		AM_PORTABS   = 3'h4,
		AM_OFFSET16  = 3'h5,
		AM_DIRECT    = 3'h6
	} addrMode_t;

	// coefficient pointer forms
	typedef enum logic [1:0] {
		CP_PLAIN = 2'h0,
		CP_INC   = 2'h1,
		CP_DEC   = 2'h2,
		CP_INDEX = 2'h3
	} coefForm_t;

	// memory operand width modifiers
	typedef enum logic [1:0] {
		MW_WORD = 2'h0,
		MW_LONG = 2'h1,
		MW_DUAL = 2'h2,
		MW_BYTE = 2'h3
	} memWidth_t;

	// accumulator half select codes
	localparam logic [1:0] ACC_FULL  = 2'h0;
	localparam logic [1:0] ACC_UPPER = 2'h1;
	localparam logic [1:0] ACC_LOWER = 2'h2;

	// pointer modification codes
	localparam logic [1:0] PM_NONE = 2'h0;
	localparam logic [1:0] PM_INC  = 2'h1;
	localparam logic [1:0] PM_DEC  = 2'h2;
	localparam logic [1:0] PM_IDX  = 2'h3;

	// decoded view of one instruction slot
	typedef struct packed {
		logic               valid;
		instrClass_t        cls;
		logic               parEnable;
		logic               softDualOk;
		addrMode_t          mode;
		logic               isMmr;
		logic               ioAccess;
		logic               ioLegal;
		memWidth_t          width;
		logic               byteHigh;
		logic               hasQualifier;
		logic               modStackPtr;
		logic               usesCoef;
		logic               coefUns;
		coefForm_t          coefForm;
		logic               usesXY;
		logic               xUns;
		logic               yUns;
		logic [1:0]         accHalf;
		logic [OP_W-1:0]    ops;
		logic [CNT_W-1:0]   daUse;
		logic               caUse;
		logic               saUse;
		logic [CNT_W-1:0]   drUse;
		logic               crUse;
		logic [CNT_W-1:0]   dwUse;
		logic               acbUse;
		logic [REG_W-1:0]   regWrites;
		logic [REG_W-1:0]   swapRegs;
		logic [ST_W-1:0]    stWrites;
		logic               ptrMod;
		logic [IDX_W-1:0]   ptrIdx;
		logic [1:0]         ptrKind;
	} slot_t;

endpackage : pair_check_pkg

// ### hdl/slot_bus_if.sv
`timescale 1ns/1ns
// per-slot legality summary between the slot checker and the pair logic
interface slot_bus_if;
	import pair_check_pkg::*;
	logic               ioFault;
	logic               mmrByteFault;
	logic               noPair;
	logic               noRepeat;
	logic               forbidQual;
	logic               stackCall;
	modport source  (output ioFault, mmrByteFault, noPair, noRepeat, forbidQual, stackCall);
	modport user    (input  ioFault, mmrByteFault, noPair, noRepeat, forbidQual, stackCall);
endinterface : slot_bus_if

// ### hdl/slot_check.sv
`timescale 1ns/1ns
// classifies one decoded instruction slot
module slot_check (
	input  wire pair_check_pkg::slot_t slot,
	slot_bus_if.source                 sb
);
	import pair_check_pkg::*;

	// byte access to a memory-mapped register
	assign sb.mmrByteFault = slot.valid & slot.isMmr & (slot.width == MW_BYTE);
	// long-offset or delay forms may not reach I/O space
	wire ioBadOffset = slot.ioAccess & (slot.mode == AM_OFFSET16);
	wire ioBadDelay  = slot.ioAccess & (slot.cls == CLS_DELAY);
	assign sb.ioFault = slot.valid & (ioBadOffset | ioBadDelay | (slot.ioAccess & ~slot.ioLegal));

	// classes and modes that may never share the cycle
	wire wideMode = (slot.mode == AM_ABS16) | (slot.mode == AM_ABS23) | (slot.mode == AM_PORTABS)
		| (slot.mode == AM_OFFSET16);
	wire loneCls  = (slot.cls == CLS_BRANCH_FAR) | (slot.cls == CLS_CALL_FAR) | (slot.cls == CLS_IDLE)
		| (slot.cls == CLS_INTR) | (slot.cls == CLS_RESET) | (slot.cls == CLS_TRAP);
	assign sb.noPair     = slot.valid & (wideMode | loneCls);
	assign sb.forbidQual = slot.valid & slot.hasQualifier;

	// stack-using flow classes
	assign sb.stackCall = slot.valid & ((slot.cls == CLS_CALL) | (slot.cls == CLS_CALL_FAR)
		| (slot.cls == CLS_PUSH) | (slot.cls == CLS_POP) | (slot.cls == CLS_RETURN)
		| (slot.cls == CLS_RETINT) | (slot.cls == CLS_TRAP) | (slot.cls == CLS_INTR));

	// classes that a single-repeat may not repeat
	assign sb.noRepeat = slot.valid & (slot.cls != CLS_PLAIN) & (slot.cls != CLS_PUSH)
		& (slot.cls != CLS_POP) & (slot.cls != CLS_SWAP) & (slot.cls != CLS_DELAY)
		| slot.valid & (slot.mode == AM_ABS23);

endmodule : slot_check

// ### dv/dsp_parallel_pair_checker_asserts.sv
`timescale 1ns/1ns
// one-cycle decode relations between slot fields and flags or operands
module dsp_parallel_pair_checker_asserts (
	input wire logic                         sys_clk,
	input wire logic                         sys_rst,
	input wire logic                         decodeValid,
	input wire pair_check_pkg::slot_t        slotA,
	input wire pair_check_pkg::slot_t        slotB,
	input wire logic                         repeatActive,
	input wire logic                         legacy_compat_mode,
	input wire logic [15:0]                  temp_register_zero,
	input wire logic [15:0]                  aux_register_zero,
	input wire logic [15:0]                  coefficient_pointer,
	input wire logic [31:0]                  memReadData,
	input wire logic [39:0]                  accValue,
	input wire logic                         illegalPair,
	input wire logic                         illegalRepeat,
	input wire logic                         bus_error_irq,
	input wire logic                         issueDual,
	input wire logic [pair_check_pkg::ST_W-1:0] statusUndefined,
	input wire logic [15:0]                  coefPtrNext,
	input wire logic [31:0]                  operandLong,
	input wire logic [15:0]                  operandHigh,
	input wire logic [15:0]                  operandLow,
	input wire logic [15:0]                  accOperand
);
	import pair_check_pkg::*;
	// decode qualifiers and precomputed expectations
	wire                  aUp    = decodeValid && slotA.valid;
	wire                  pairUp = aUp && slotB.valid;
	wire [15:0]           idxSum = coefficient_pointer + (legacy_compat_mode ? aux_register_zero : temp_register_zero);
	wire [ST_W-1:0]       stBoth = slotA.stWrites & slotB.stWrites;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_opShare; pairUp && |(slotA.ops & slotB.ops) |=> illegalPair && !issueDual; endproperty
	a_opShare: assert property (p_opShare) else $error("shared operator pair not flagged");
	property p_noEnable;
		pairUp && !slotA.parEnable && !slotB.parEnable && !slotA.softDualOk && !slotB.softDualOk |=> illegalPair;
	endproperty
	a_noEnable: assert property (p_noEnable) else $error("pair without enable not flagged");
	property p_solo; pairUp && slotA.cls inside {CLS_IDLE, CLS_TRAP, CLS_RESET, CLS_INTR} |=> illegalPair; endproperty
	a_solo: assert property (p_solo) else $error("unpairable class accepted");
	property p_mmrByte; aUp && slotA.isMmr && slotA.width == MW_BYTE |=> bus_error_irq; endproperty
	a_mmrByte: assert property (p_mmrByte) else $error("byte access to mapped register missed");
	property p_ioDelay; aUp && slotA.ioAccess && slotA.cls == CLS_DELAY |=> bus_error_irq; endproperty
	a_ioDelay: assert property (p_ioDelay) else $error("delay on port space missed");
	property p_long; aUp && slotA.width == MW_LONG |=> operandLong == $past(memReadData); endproperty
	a_long: assert property (p_long) else $error("long operand wrong");
	property p_dual; aUp && slotA.width == MW_DUAL |=> {operandHigh, operandLow} == $past(memReadData); endproperty
	a_dual: assert property (p_dual) else $error("dual halves wrong");
	property p_accUp; aUp && slotA.accHalf == ACC_UPPER |=> accOperand == $past(accValue[31:16]); endproperty
	a_accUp: assert property (p_accUp) else $error("upper accumulator half wrong");
	property p_coefIdx; aUp && slotA.usesCoef && slotA.coefForm == CP_INDEX |=> coefPtrNext == $past(idxSum); endproperty
	a_coefIdx: assert property (p_coefIdx) else $error("indexed coefficient pointer wrong");
	property p_repeat;
		repeatActive && aUp && slotA.cls inside {CLS_BRANCH, CLS_RETURN, CLS_STBIT, CLS_RPTCREAD, CLS_ROUND}
		|=> illegalRepeat;
	endproperty
	a_repeat: assert property (p_repeat) else $error("forbidden repeat accepted");
	property p_status; pairUp |=> statusUndefined == $past(stBoth); endproperty
	a_status: assert property (p_status) else $error("undefined status mask wrong");
	// main scenarios reached
	c_dual: cover property (pairUp ##1 issueDual);
	c_berr: cover property (aUp ##1 bus_error_irq);
	c_rep: cover property (repeatActive ##1 illegalRepeat);
endmodule : dsp_parallel_pair_checker_asserts

bind dsp_parallel_pair_checker dsp_parallel_pair_checker_asserts chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.decodeValid(decodeValid), .slotA(slotA), .slotB(slotB), .repeatActive(repeatActive),
	.legacy_compat_mode(legacy_compat_mode), .temp_register_zero(temp_register_zero),
	.aux_register_zero(aux_register_zero), .coefficient_pointer(coefficient_pointer), .memReadData(memReadData),
	.accValue(accValue), .illegalPair(illegalPair), .illegalRepeat(illegalRepeat), .bus_error_irq(bus_error_irq),
	.issueDual(issueDual), .statusUndefined(statusUndefined), .coefPtrNext(coefPtrNext),
	.operandLong(operandLong), .operandHigh(operandHigh), .operandLow(operandLow), .accOperand(accOperand));

// ### dv/pipe_source_model.sv
`timescale 1ns/1ns
// execution pipeline side: register values and operand sources
module pipe_source_model #(
	parameter logic [15:0] TEMP_VAL = 16'h0012,
	parameter logic [15:0] AUX_VAL  = 16'h0300,
	parameter logic [15:0] CPTR_VAL = 16'h1000,
	parameter logic [15:0] WORD  = 16'hC3A5,
	parameter logic [31:0] SPLIT = 32'hABCD1234,
	parameter logic [39:0] ACC   = 40'h123456789A
) (
	input  wire logic        sys_clk,
	input  wire logic        split,
	output logic [15:0]      tempReg,
	output logic [15:0]      auxReg,
	output logic [15:0]      coefPtr,
	output logic [31:0]      memData,
	output logic [39:0]      accData
);
	assign tempReg = TEMP_VAL;
	assign auxReg  = AUX_VAL;
	assign coefPtr = CPTR_VAL;
	assign accData = ACC;
	// memory word repeated in both halves unless distinct halves are asked for
	always @(negedge sys_clk) begin
		memData <= split ? SPLIT : {WORD, WORD};
	end
endmodule : pipe_source_model

// ### dv/dsp_parallel_pair_checker_bench.sv
`timescale 1ns/1ns
module dsp_parallel_pair_checker_bench;
	import pair_check_pkg::*;
	logic              sys_clk, sys_rst, decodeValid, repeatActive, legacyMode, split;
	logic              illegalPair, illegalRepeat, busErr, issueDual;
	slot_t             slotA, slotB, a, b, c, d;
	logic [15:0]       tReg, aReg, cPtr, coefAddr, coefNext, opHigh, opLow, accOp, expPtr;
	logic [31:0]       memData, opLong;
	logic [39:0]       accData;
	logic [ST_W-1:0]   stUndef;
	logic [7:0]        byteOp;
	int                failures, n_compared;
	instrClass_t       solo[6] = '{CLS_BRANCH_FAR, CLS_CALL_FAR, CLS_IDLE, CLS_INTR, CLS_RESET, CLS_TRAP};
	instrClass_t       stk[5]  = '{CLS_CALL, CLS_PUSH, CLS_POP, CLS_RETURN, CLS_RETINT};
	addrMode_t         wide[4] = '{AM_ABS16, AM_ABS23, AM_PORTABS, AM_OFFSET16};

	pipe_source_model src_u (.sys_clk(sys_clk), .split(split), .tempReg(tReg), .auxReg(aReg), .coefPtr(cPtr),
		.memData(memData), .accData(accData));
	dsp_parallel_pair_checker dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .decodeValid(decodeValid),
		.slotA(slotA), .slotB(slotB), .repeatActive(repeatActive), .legacy_compat_mode(legacyMode),
		.temp_register_zero(tReg), .aux_register_zero(aReg), .coefficient_pointer(cPtr), .memReadData(memData),
		.accValue(accData), .illegalPair(illegalPair), .illegalRepeat(illegalRepeat), .bus_error_irq(busErr),
		.issueDual(issueDual), .statusUndefined(stUndef), .coefAddr(coefAddr), .coefPtrNext(coefNext),
		.operandLong(opLong), .operandHigh(opHigh), .operandLow(opLow), .accOperand(accOp), .byteOperand(byteOp));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task check(input string name, input logic [39:0] seen, input logic [39:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	// one decode cycle; results stand until the following rising edge
	task decode(input slot_t sa, input slot_t sb, input logic rep);
		@(negedge sys_clk);
		slotA = sa;
		slotB = sb;
		repeatActive = rep;
		decodeValid = 1'b1;
		@(negedge sys_clk);
		decodeValid = 1'b0;
		repeatActive = 1'b0;
	endtask : decode

	task pairTest(input slot_t sa, input slot_t sb, input logic expIll);
		decode(sa, sb, 1'b0);
		check("illegalPair", illegalPair, expIll);
		check("issueDual", issueDual, !expIll);
	endtask : pairTest

	task soloTest(input slot_t sa, input logic rep, input logic expErr, input logic expRep);
		decode(sa, '0, rep);
		check("bus_error_irq", busErr, expErr);
		check("illegalRepeat", illegalRepeat, expRep);
	endtask : soloTest

	function slot_t base(input int op);
		slot_t s;
		s = '0;
		s.valid = 1'b1;
		s.ioLegal = 1'b1;
		s.ops[op] = 1'b1;
		return s;
	endfunction : base

	task report_and_stop();
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	initial begin
		#(1000 * 20);
		failures++;
		report_and_stop();
	end

	initial begin
		{decodeValid, repeatActive, legacyMode, split} = '0;
		slotA = '0;
		slotB = '0;
		failures = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		repeat (20) @(negedge sys_clk);
		sys_rst = 1'b0;
		check("flags", {illegalPair, illegalRepeat, busErr, issueDual}, 40'h0);
		a = base(OP_DALU);
		a.parEnable = 1'b1;
		b = base(OP_AALU);
		pairTest(a, b, 1'b0);
		c = a; c.parEnable = 1'b0;
		pairTest(c, b, 1'b1);
		d = b; c.softDualOk = 1'b1; d.softDualOk = 1'b1;
		pairTest(c, d, 1'b0);
		c = b; c.ops = a.ops;
		pairTest(a, c, 1'b1);
		foreach (wide[i]) begin c = b; c.mode = wide[i]; pairTest(a, c, 1'b1); end
		foreach (solo[i]) begin c = a; c.cls = solo[i]; pairTest(c, b, 1'b1); end
		c = b; c.hasQualifier = 1'b1;
		pairTest(a, c, 1'b1);
		c = b; c.regWrites = 32'h00000010; d = a; d.regWrites = 32'h00000010;
		pairTest(d, c, 1'b1);
		d = a; d.cls = CLS_SWAP; d.swapRegs = 32'h00000010;
		pairTest(d, c, 1'b1);
		c = b; c.ptrMod = 1'b1; c.ptrIdx = 4'h2; c.ptrKind = PM_INC; d = c; d.ops = a.ops; d.ptrKind = PM_DEC;
		d.parEnable = 1'b1;
		pairTest(d, c, 1'b1);
		d = a; d.modStackPtr = 1'b1;
		foreach (stk[i]) begin c = b; c.cls = stk[i]; pairTest(d, c, 1'b1); end
		c = b; c.daUse = 2'h2; d = a; d.daUse = 2'h1;
		pairTest(d, c, 1'b1);
		c = b; c.crUse = 1'b1; d = a; d.crUse = 1'b1;
		pairTest(d, c, 1'b1);
		c = b; c.stWrites = 16'h0009; d = a; d.stWrites = 16'h0003;
		decode(d, c, 1'b0);
		check("statusUndefined", stUndef, 40'h1);
		c = b; c.usesCoef = 1'b1; c.coefUns = 1'b1; d = a; d.usesCoef = 1'b1;
		pairTest(d, c, 1'b1);
		d.coefUns = 1'b1;
		pairTest(d, c, 1'b0);
		c = b; c.usesXY = 1'b1; c.xUns = 1'b1;
		pairTest(a, c, 1'b1);
		c.yUns = 1'b1;
		pairTest(a, c, 1'b0);
		for (int k = 1; k <= 17; k++) begin d = a; d.cls = instrClass_t'(k); soloTest(d, 1'b1, 1'b0, 1'b1); end
		soloTest(a, 1'b1, 1'b0, 1'b0);
		d = a; d.isMmr = 1'b1; d.width = MW_BYTE;
		soloTest(d, 1'b0, 1'b1, 1'b0);
		d.isMmr = 1'b0; d.byteHigh = 1'b1;
		soloTest(d, 1'b0, 1'b0, 1'b0);
		check("byteHigh", byteOp, 40'hC3);
		d.byteHigh = 1'b0;
		decode(d, '0, 1'b0);
		check("byteLow", byteOp, 40'hA5);
		d = a; d.ioAccess = 1'b1; d.mode = AM_INDIRECT;
		soloTest(d, 1'b0, 1'b0, 1'b0);
		d.mode = AM_OFFSET16;
		soloTest(d, 1'b0, 1'b1, 1'b0);
		d.mode = AM_INDIRECT; d.cls = CLS_DELAY;
		soloTest(d, 1'b0, 1'b1, 1'b0);
		d.cls = CLS_PLAIN; d.ioLegal = 1'b0;
		soloTest(d, 1'b0, 1'b1, 1'b0);
		split = 1'b1;
		d = a; d.width = MW_LONG;
		decode(d, '0, 1'b0);
		check("operandLong", opLong, 40'hABCD1234);
		d.width = MW_DUAL;
		decode(d, '0, 1'b0);
		check("operandHalves", {opHigh, opLow}, 40'hABCD1234);
		d = a; d.accHalf = ACC_UPPER;
		decode(d, '0, 1'b0);
		check("accUpper", accOp, 40'h3456);
		d.accHalf = ACC_LOWER;
		decode(d, '0, 1'b0);
		check("accLower", accOp, 40'h789A);
		for (int lg = 0; lg < 2; lg++) begin
			for (int f = 0; f < 4; f++) begin
				legacyMode = lg[0];
				d = a; d.usesCoef = 1'b1; d.coefForm = coefForm_t'(f);
				expPtr = (f == 0) ? 16'h1000 : (f == 1) ? 16'h1001 : (f == 2) ? 16'h0FFF : (lg ? 16'h1300 : 16'h1012);
				decode(d, '0, 1'b0);
				check("coefPtrNext", coefNext, {24'h0, expPtr});
				check("coefAddr", coefAddr, 40'h1000);
			end
		end
		report_and_stop();
	end
endmodule : dsp_parallel_pair_checker_bench
